// file: hdl/irh_map.svh
// constants for the interrupt request handling block
`ifndef IRH_MAP_SVH
`define IRH_MAP_SVH
`define IRH_SRC_CNT      8
`define IRH_NUM_W        3
`define IRH_LVL_W        3
`define IRH_LVL_OFF      3'h0
`define IRH_ADDR_W       20
`define IRH_ACK_ADDR     20'h00000
`define IRH_SP_W         16
`define IRH_SP_RST       16'h0000
`define IRH_PREFETCH_W   3
`define IRH_PREFETCH_BYTES 3'h4
`define IRH_FLAG_CLR     1'b0
`endif

// file: hdl/irh_pkg.sv
// types for the interrupt request handling block
`include "irh_map.svh"
package irh_pkg;
  typedef logic [`IRH_NUM_W-1:0] irh_num_t;
  typedef logic [`IRH_LVL_W-1:0] irh_lvl_t;

  typedef struct packed {
    logic     valid;
    irh_num_t idx;
    irh_lvl_t level;
    logic     flag;
    logic     bitwise;
  } irh_ctrl_wr_t;

  typedef struct packed {
    irh_num_t num;
    irh_lvl_t level;
  } irh_ack_t;

  typedef struct packed {
    logic                     valid;
    logic [`IRH_ADDR_W-1:0]   addr;
  } irh_addr_t;

  typedef enum logic [1:0] {
    IRH_RUN      = 2'h0,
    IRH_PREFETCH = 2'h1,
    IRH_HALTED   = 2'h3
  } irh_halt_t;

  typedef struct packed {
    logic [`IRH_SRC_CNT-1:0]   flag;
    irh_lvl_t [`IRH_SRC_CNT-1:0] level;
    irh_ack_t                  ack_data;
    logic                      ack_valid;
    logic                      irq_req;
    irh_ack_t                  irq_info;
    logic                      match_req;
    logic                      step_req;
    logic                      break_req;
    logic [`IRH_SP_W-1:0]      stack_pointer;
    irh_halt_t                 halt;
    logic [`IRH_PREFETCH_W-1:0] prefetch_cnt;
    logic                      stop_pending;
    logic                      clocks_off;
  } irh_state_t;
endpackage : irh_pkg

// file: hdl/irh_core.sv
// interrupt request flags, acknowledge, special sources, stack pointer and halt prefetch
//
// Summary of operation
// RULE_01: acknowledge reads address zero, clears accepted flag
// RULE_02: program read of zero clears highest enabled flag
// RULE_03: stack pointer resets to zero
// RULE_04: source reconfiguration may set request flag
// RULE_05: software clears flag after source change
// RULE_06: software edits control only when quiet
// RULE_07: bitwise writes keep arriving request flag
// RULE_08: software clears flag with plain move
// RULE_09: software delays re-enabling after control write
// RULE_10: address match requests before matched instruction
// RULE_11: single step requests per instruction, blocks others
// RULE_12: break instruction raises break request
// RULE_13: four bytes prefetched before wait or stop
// RULE_14: per-source flag, set by event, cleared
`timescale 1ns/1ps
`include "irh_map.svh"
module irh_core
  import irh_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic                      nrst,
  input  wire logic [`IRH_SRC_CNT-1:0]   src_event,
  input  wire logic [`IRH_SRC_CNT-1:0]   src_reconfig,
  input  wire irh_ctrl_wr_t              ctrl_wr,
  input  wire irh_addr_t                 cpu_read,
  input  wire irh_addr_t                 fetch,
  input  wire logic [`IRH_ADDR_W-1:0]    match_addr,
  input  wire logic                      match_en,
  input  wire logic                      step_en,
  input  wire logic                      instr_done,
  input  wire logic                      break_instruction,
  input  wire logic [2:0]                special_ack,
  input  wire logic                      sp_wr,
  input  wire logic [`IRH_SP_W-1:0]      sp_wdata,
  input  wire logic                      wait_exec,
  input  wire logic                      all_clocks_stop_bit,
  input  wire logic                      byte_fetch,
  input  wire logic                      wake,
  output logic [`IRH_SRC_CNT-1:0]        request_flag,
  output irh_ack_t                       ack_data,
  output logic                           ack_valid,
  output logic                           irq_req,
  output irh_ack_t                       irq_info,
  output logic                           match_req,
  output logic                           step_req,
  output logic                           break_req,
  output logic [`IRH_SP_W-1:0]           stack_pointer,
  output logic                           queue_halted,
  output logic                           clocks_off
);

  irh_state_t              st_reg;
  irh_state_t              st_next;
  logic [`IRH_SRC_CNT-1:0] eligible;
  logic                    win_any;
  irh_num_t                win_num;
  irh_lvl_t                win_lvl;
  logic                    ack_hit;
  logic                    halt_cmd;
  logic                    match_hit;
  logic                    step_hit;
  logic [`IRH_PREFETCH_W-1:0] cnt_inc;

  // a source competes only while its flag is set and its level is not off
  genvar g;
  generate
    for (g = 0; g < `IRH_SRC_CNT; g++) begin : g_elig
      assign eligible[g] = st_reg.flag[g] && (st_reg.level[g] != `IRH_LVL_OFF);
    end
  endgenerate

  // highest level wins, lowest number breaks a tie
  always_comb begin
    win_any = 1'b0;
    win_num = '0;
    win_lvl = `IRH_LVL_OFF;
    for (int i = 0; i < `IRH_SRC_CNT; i++) begin
      if (eligible[i] && (!win_any || st_reg.level[i] > win_lvl)) begin
        win_any = 1'b1;
        win_num = irh_num_t'(i);
        win_lvl = st_reg.level[i];
      end
    end
  end

  // a stray program read of address zero acts as an acknowledge and drops the top request
  assign ack_hit  = cpu_read.valid && (cpu_read.addr == `IRH_ACK_ADDR); // RULE_01 RULE_02
  assign halt_cmd = wait_exec || all_clocks_stop_bit;

  // special source triggers
  assign match_hit = match_en && fetch.valid && (fetch.addr == match_addr); // RULE_10
  assign step_hit  = step_en && instr_done;                                 // RULE_11
  // bytes taken by the queue after the halting instruction
  assign cnt_inc   = st_reg.prefetch_cnt + 3'h1;

  always_comb begin
    st_next           = st_reg;
    // the answer strobe lasts a single cycle
    st_next.ack_valid = 1'b0;

    // acknowledge cycle: answer number and level, drop the winner's flag
    // with no eligible source the answer is zero and nothing is cleared
    if (ack_hit) begin
      st_next.ack_valid      = 1'b1;                         // RULE_01
      st_next.ack_data.num   = win_num;                      // RULE_01
      st_next.ack_data.level = win_lvl;                      // RULE_01
      if (win_any) begin
        st_next.flag[win_num] = `IRH_FLAG_CLR;               // RULE_02
      end
    end

    // control register write: move may clear the flag, bitwise leaves it
    // a flag write of one is ignored: only hardware sets flags
    if (ctrl_wr.valid) begin
      st_next.level[ctrl_wr.idx] = ctrl_wr.level;
      if (!ctrl_wr.bitwise && (ctrl_wr.flag == `IRH_FLAG_CLR)) begin
        st_next.flag[ctrl_wr.idx] = `IRH_FLAG_CLR;           // RULE_14
      end
    end

    // events applied last so a set in the clearing cycle is kept
    // a source change may look like an edge, so it raises the flag too
    for (int i = 0; i < `IRH_SRC_CNT; i++) begin
      if (src_event[i]) begin
        st_next.flag[i] = 1'b1;                              // RULE_14 RULE_07
      end
      if (src_reconfig[i]) begin
        st_next.flag[i] = 1'b1;                              // RULE_04
      end
    end

    // maskable request to the cpu, held off while single stepping
    st_next.irq_req  = win_any && !step_en && !ack_hit;      // RULE_11
    st_next.irq_info.num   = win_num;
    st_next.irq_info.level = win_lvl;

    // special sources, cleared by their acknowledge, set wins
    if (special_ack[0]) begin
      st_next.match_req = 1'b0;
    end
    if (special_ack[1]) begin
      st_next.step_req = 1'b0;
    end
    if (special_ack[2]) begin
      st_next.break_req = 1'b0;
    end
    if (match_hit) begin
      st_next.match_req = 1'b1;                              // RULE_10
    end
    if (step_hit) begin
      st_next.step_req = 1'b1;                               // RULE_11
    end
    if (break_instruction) begin
      st_next.break_req = 1'b1;                              // RULE_12
    end

    // zero until software loads it, so an interrupt taken earlier uses a bad stack
    if (sp_wr) begin
      st_next.stack_pointer = sp_wdata;
    end

    // wait or stop lets the queue take four more bytes before halting
    // software places four no-ops after the halting instruction for this reason
    case (st_reg.halt)
      IRH_RUN: begin
        if (halt_cmd) begin
          st_next.halt         = IRH_PREFETCH;               // RULE_13
          st_next.prefetch_cnt = '0;
          st_next.stop_pending = all_clocks_stop_bit;
        end
      end
      IRH_PREFETCH: begin
        if (byte_fetch) begin
          st_next.prefetch_cnt = cnt_inc;
          if (cnt_inc == `IRH_PREFETCH_BYTES) begin
            st_next.halt       = IRH_HALTED;                 // RULE_13
            st_next.clocks_off = st_reg.stop_pending;
          end
        end
      end
      IRH_HALTED: begin
        if (wake) begin
          st_next.halt         = IRH_RUN;
          st_next.clocks_off   = 1'b0;
          st_next.stop_pending = 1'b0;
        end
      end
      default: begin
        // unused code falls back to run
        st_next.halt = IRH_RUN;
      end
    endcase
  end

  // synchronous reset clears all state; stack pointer and halt take their reset values
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg               <= '0;
      st_reg.stack_pointer <= `IRH_SP_RST;                   // RULE_03
      st_reg.halt          <= IRH_RUN;
    end else begin
      st_reg <= st_next;
    end
  end

  // every output is a field or bit of the state register
  assign request_flag  = st_reg.flag;
  assign ack_data      = st_reg.ack_data;
  assign ack_valid     = st_reg.ack_valid;
  assign irq_req       = st_reg.irq_req;
  assign irq_info      = st_reg.irq_info;
  assign match_req     = st_reg.match_req;
  assign step_req      = st_reg.step_req;
  assign break_req     = st_reg.break_req;
  assign stack_pointer = st_reg.stack_pointer;
  assign queue_halted  = st_reg.halt[1];
  assign clocks_off    = st_reg.clocks_off;

endmodule : irh_core

// file: verif/irh_checker.sv
// port assertions for the interrupt request handling block
`timescale 1ns/1ps
`include "irh_map.svh"
module irh_checker
  import irh_pkg::*;
(
  input logic        ref_clk,
  input logic        nrst,
  input logic [7:0]  src_event,
  input logic [7:0]  src_reconfig,
  input irh_addr_t   cpu_read,
  input irh_addr_t   fetch,
  input logic [19:0] match_addr,
  input logic        match_en,
  input logic        step_en,
  input logic        instr_done,
  input logic        break_instruction,
  input logic [7:0]  request_flag,
  input logic        ack_valid,
  input logic        irq_req,
  input logic        match_req,
  input logic        step_req,
  input logic        break_req,
  input logic [15:0] stack_pointer
);
  wire ackc = cpu_read.valid && cpu_read.addr == '0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ack_answer_a: assert property (ackc |=> ack_valid)
    else $error("read of zero not answered");
  ack_cause_a: assert property (ack_valid |-> $past(ackc))
    else $error("answer without read of zero");
  ack_quiet_a: assert property (ackc |=> !irq_req)
    else $error("request kept after acknowledge");
  sp_reset_a: assert property ($rose(nrst) |-> stack_pointer == 16'h0000)
    else $error("stack pointer not zero after reset");
  flag_set_a: assert property (
    |src_event |=> (request_flag & $past(src_event)) == $past(src_event))
    else $error("event did not set its flag");
  reconf_set_a: assert property (
    |src_reconfig |=> (request_flag & $past(src_reconfig)) == $past(src_reconfig))
    else $error("change did not set its flag");
  match_raise_a: assert property (
    fetch.valid && match_en && fetch.addr == match_addr |=> match_req)
    else $error("address match missed");
  step_raise_a: assert property (step_en && instr_done |=> step_req)
    else $error("step request missed");
  step_quiet_a: assert property (step_en [*2] |=> !irq_req)
    else $error("request while stepping");
  break_raise_a: assert property (break_instruction |=> break_req)
    else $error("break request missed");
endmodule : irh_checker

bind irh_core irh_checker irh_checker_i (.*);

// file: verif/interrupt_request_handling_test.sv
// randomised bench for the interrupt request handling block
`timescale 1ns/1ps
`include "irh_map.svh"
module interrupt_request_handling_test
  import irh_pkg::*;
;
  logic ref_clk = 0, nrst = 0, match_en = 0, step_en = 0, instr_done = 0, sp_wr = 0;
  logic break_instruction = 0, wait_exec = 0, all_clocks_stop_bit = 0, byte_fetch = 0;
  logic wake = 0, ack_valid, irq_req, match_req, step_req, break_req, queue_halted;
  logic clocks_off, ee = 0, eq = 0;
  logic [7:0] src_event = '0, src_reconfig = '0, request_flag, mf = '0, ev, rc;
  logic [2:0] special_ack = '0;
  logic [15:0] sp_wdata = '0, stack_pointer;
  logic [19:0] match_addr = '0;
  irh_ctrl_wr_t ctrl_wr = '0, w;
  irh_addr_t cpu_read = '0, fetch = '0, r;
  irh_ack_t ack_data, irq_info, ea = '0;
  irh_lvl_t ml [8] = '{default: '0};
  int err_count = 0, num_checks = 0;

  irh_core irh_core_i (.*);

  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    num_checks++;
    if (e !== s) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic final_report;
    if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report

  // highest level wins, lower index on a tie, level zero disabled
  function automatic irh_ack_t win(logic [7:0] f);
    win = '0;
    for (int i = 7; i >= 0; i--)
      if (f[i] && ml[i] != '0 && ml[i] >= win.level) win = {i[2:0], ml[i]};
  endfunction : win

  initial begin
    void'($urandom(75558));
    repeat (2) @(posedge ref_clk);
    nrst <= 1;
    @(posedge ref_clk);
    #1 chk("sp", 0, stack_pointer);
    // corner: source change, then a plain-move clear while the source is quiet
    @(posedge ref_clk);
    src_reconfig <= 8'h08;
    @(posedge ref_clk);
    src_reconfig <= '0;
    ctrl_wr <= '{valid: 1'b1, idx: 3'h3, level: 3'h2, flag: 1'b0, bitwise: 1'b0};
    #1 chk("reconfig flag", 8'h08, request_flag);
    @(posedge ref_clk);
    ctrl_wr <= '0;
    repeat (2) @(posedge ref_clk);
    #1 chk("move clear", 0, {irq_req, request_flag});
    ml[3] = 3'h2;
    repeat (400) begin
      @(posedge ref_clk);
      ev = $urandom & $urandom & $urandom;
      rc = ($urandom % 8 == 0) ? 8'h01 << ($urandom % 8) : 8'h00;
      w = $urandom;
      w.valid = $urandom % 3 == 0;
      r.valid = $urandom % 3 == 0;
      r.addr = $urandom % 2;
      src_event <= ev;
      src_reconfig <= rc;
      ctrl_wr <= w;
      cpu_read <= r;
      #1 chk("flags", mf, request_flag);
      chk("ack", ee, ack_valid);
      if (ee) chk("info", ea, ack_data);
      chk("irq pend", eq, irq_req);
      chk("irq info", ea, irq_info);
      ee = r.valid && r.addr == '0;
      ea = win(mf);
      eq = ea.level != '0 && !ee;
      if (ee && ea.level != '0) mf[ea.num] = 0;
      if (w.valid) begin
        ml[w.idx] = w.level;
        if (!w.bitwise && !w.flag) mf[w.idx] = 0;
      end
      mf = mf | ev | rc;
    end
    @(posedge ref_clk);
    src_event <= '0;
    src_reconfig <= '0;
    ctrl_wr <= '0;
    cpu_read <= '0;
    match_en <= 1;
    match_addr <= 20'h12345;
    fetch <= {1'h1, 20'h12345};
    break_instruction <= 1;
    step_en <= 1;
    instr_done <= 1;
    sp_wr <= 1;
    sp_wdata <= 16'h5aa5;
    @(posedge ref_clk);
    fetch <= '0;
    break_instruction <= 0;
    instr_done <= 0;
    sp_wr <= 0;
    special_ack <= 3'h7;
    #1 chk("specials", 3'h7, {match_req, step_req, break_req});
    chk("irq", 0, irq_req);
    chk("sp load", 16'h5aa5, stack_pointer);
    repeat (2) @(posedge ref_clk);
    special_ack <= '0;
    step_en <= 0;
    #1 chk("cleared", 0, {match_req, step_req, break_req});
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      wait_exec <= !k;
      all_clocks_stop_bit <= k[0];
      @(posedge ref_clk);
      wait_exec <= 0;
      all_clocks_stop_bit <= 0;
      byte_fetch <= 1;
      repeat (3) @(posedge ref_clk);
      #1 chk("early halt", 0, queue_halted);
      @(posedge ref_clk);
      byte_fetch <= 0;
      wake <= 1;
      #1 chk("halted", 1, queue_halted);
      chk("clocks off", k, clocks_off);
      @(posedge ref_clk);
      wake <= 0;
      #1 chk("woken", 0, {queue_halted, clocks_off});
    end
    final_report();
  end

  initial begin
    #10000;
    err_count++;
    final_report();
  end
endmodule : interrupt_request_handling_test
